/* File: hdl/data_move_rotate_flags_consts.vh */
// Constants for the data move and rotate datapath
// Function
// - General move copies byte, word or long between memory and registers.
// - Address register move takes word or long only, writes 32 bits.
// - Register swap exchanges full 32-bit contents of two registers.
// - Effective address load writes base plus offset, no memory access.
// - Frame link: pointer minus 4, store, copy pointer, add offset.
// - Frame unlink: pointer from register, reload register, pointer plus 4.
// - Effective address push: pointer minus 4, store address at top.
// - Multi-register move stores or loads listed registers; words widen.
// - Byte-lane store puts high byte first on every second address.
// - Byte-lane load fills bytes from alternate addresses; word uses two.
// - Quick move writes an 8-bit immediate as a 32-bit value.
// - Rotate right keeps X, clears V, carry is last bit out or zero.
`ifndef DATA_MOVE_ROTATE_FLAGS_CONSTS_VH
`define DATA_MOVE_ROTATE_FLAGS_CONSTS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CMD 8'h00
`define OFS_SRCA 8'h04
`define OFS_DSTA 8'h08
`define OFS_DISP 8'h0C
`define OFS_STAT 8'h10
`define OFS_RSEL 8'h14
`define OFS_RDAT 8'h18
// ----------------------------------------
// Operation codes
// ----------------------------------------
`define OP_MOVE 4'h0
`define OP_ADDR_MOVE 4'h1
`define OP_SWAP 4'h2
`define OP_EA_LOAD 4'h3
`define OP_LINK 4'h4
`define OP_UNLINK 4'h5
`define OP_EA_PUSH 4'h6
`define OP_MULTI 4'h7
`define OP_PBYTE 4'h8
`define OP_QUICK 4'h9
`define OP_ROT_RIGHT 4'hA
// ----------------------------------------
// Sizes, field positions, constants
// ----------------------------------------
`define SZ_BYTE 2'h0
`define SZ_WORD 2'h1
`define SZ_LONG 2'h2
`define STAT_BUSY 8
`define STAT_ERR 9
`define FLG_X 4
`define STACK_IDX 4'hF
`define STACK_STEP 32'h00000004
`define PBYTE_STEP 32'h00000002
`endif

/* File: hdl/data_move_rotate_flags.v */
// Data movement and rotate-right datapath with APB control port
`include "data_move_rotate_flags_consts.vh"
`default_nettype none
module data_move_rotate_flags (
    input wire clk_sys_in,
    input wire rstn_in,
    input wire clk_en_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [7:0] paddr_in,
    input wire [31:0] pwdata_in,
    output reg [31:0] prdata_out,
    output wire pready_out,
    output wire pslverr_out,
    output reg mem_req_out,
    output reg mem_we_out,
    output reg [1:0] mem_size_out,
    output reg [31:0] mem_addr_out,
    output reg [31:0] mem_wdata_out,
    input wire [31:0] mem_rdata_in,
    input wire mem_ack_in
);
// ----------------------------------------
// Helper functions
// ----------------------------------------
function [31:0] szmask;
    input [1:0] s;
    begin
        szmask = (s == `SZ_BYTE) ? 32'h000000FF :
                 (s == `SZ_WORD) ? 32'h0000FFFF : 32'hFFFFFFFF;
    end
endfunction
function msb;
    input [31:0] v;
    input [1:0] s;
    begin
        msb = (s == `SZ_BYTE) ? v[7] : (s == `SZ_WORD) ? v[15] : v[31];
    end
endfunction
function [31:0] merge;
    input [31:0] old;
    input [31:0] nv;
    input [1:0] s;
    begin
        merge = (old & ~szmask(s)) | (nv & szmask(s));
    end
endfunction
function [31:0] sext16;
    input [15:0] v;
    begin
        sext16 = {{16{v[15]}}, v};
    end
endfunction
function [31:0] rotr;
    input [31:0] v;
    input [5:0] cnt;
    input [1:0] s;
    integer i;
    reg [31:0] t;
    begin
        t = v;
        for (i = 0; i < 64; i = i + 1) begin
            if (i < cnt) begin
                if (s == `SZ_BYTE)
                    t = {t[31:8], t[0], t[7:1]};
                else if (s == `SZ_WORD)
                    t = {t[31:16], t[0], t[15:1]};
                else
                    t = {t[0], t[31:1]};
            end
        end
        rotr = t;
    end
endfunction
// ----------------------------------------
// State
// ----------------------------------------
localparam [2:0] S_IDLE = 3'b001;
localparam [2:0] S_RUN = 3'b010;
localparam [2:0] S_MEM = 3'b100;
reg [2:0] state_r;
reg [3:0] phase_r;
reg [3:0] idx_r;
reg [31:0] cmd_r;
reg [31:0] srca_r;
reg [31:0] dsta_r;
reg [31:0] disp_r;
reg [3:0] rsel_r;
reg [4:0] ccr_r;
reg err_r;
reg [31:0] rd_r;
reg [31:0] maddr_r;
reg [31:0] rf_r [0:15];
integer k;
wire [3:0] op = cmd_r[3:0];
wire [1:0] sz = cmd_r[5:4];
wire [3:0] rx = cmd_r[11:8];
wire [3:0] ry = cmd_r[15:12];
wire dir = cmd_r[16];
wire smem = cmd_r[17];
wire dmem = cmd_r[18];
wire [3:0] ay = {1'b1, ry[2:0]};
wire [3:0] dy = {1'b0, ry[2:0]};
wire [3:0] dx = {1'b0, rx[2:0]};
wire [31:0] stk_top = rf_r[`STACK_IDX];
wire [31:0] eaddr = rf_r[rx] + disp_r;
wire busy = (state_r != S_IDLE);
wire [31:0] quick = {{24{disp_r[7]}}, disp_r[7:0]};
wire [31:0] rot = rotr(rf_r[dy], disp_r[5:0], sz);
wire [2:0] pb_last = (sz == `SZ_LONG) ? 3'd3 : 3'd1;
wire [4:0] pb_sh = {(pb_last[1:0] - idx_r[1:0]), 3'b000};
wire [31:0] pb_lane = 32'h000000FF << pb_sh;
wire [31:0] ld_val = (sz == `SZ_WORD) ? sext16(rd_r[15:0]) : rd_r;
wire [31:0] mv_val = rd_r & szmask(sz);
wire [31:0] wd_in = pwdata_in;
// ----------------------------------------
// APB decode
// ----------------------------------------
wire acc = psel_in & penable_in & clk_en_in;
wire setup = psel_in & ~penable_in & clk_en_in;
wire hit = (paddr_in[1:0] == 2'b00) & (paddr_in <= `OFS_RDAT);
wire wr_ok = acc & pwrite_in & hit & ~busy;
wire [4:0] cmd_op = {1'b0, wd_in[3:0]};
wire cmd_bad = (cmd_op > {1'b0, `OP_ROT_RIGHT}) | (wd_in[5:4] == 2'h3) |
    (((wd_in[3:0] == `OP_ADDR_MOVE) | (wd_in[3:0] == `OP_MULTI) |
    (wd_in[3:0] == `OP_PBYTE)) & (wd_in[5:4] == `SZ_BYTE));
assign pready_out = clk_en_in;
assign pslverr_out = psel_in & penable_in &
    (~hit | (pwrite_in & busy));
always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
        prdata_out <= 32'h00000000;
    end else if (setup) begin
        case (paddr_in)
            `OFS_CMD: prdata_out <= cmd_r;
            `OFS_SRCA: prdata_out <= srca_r;
            `OFS_DSTA: prdata_out <= dsta_r;
            `OFS_DISP: prdata_out <= disp_r;
            `OFS_STAT: prdata_out <= {22'h000000, err_r, busy, 3'h0, ccr_r};
            `OFS_RSEL: prdata_out <= {28'h0000000, rsel_r};
            `OFS_RDAT: prdata_out <= rf_r[rsel_r];
            default: prdata_out <= 32'h00000000;
        endcase
    end
end
// ----------------------------------------
// Register file, control and sequencer
// ----------------------------------------
always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
        state_r <= S_IDLE;
        phase_r <= 4'h0;
        idx_r <= 4'h0;
        cmd_r <= 32'h00000000;
        srca_r <= 32'h00000000;
        dsta_r <= 32'h00000000;
        disp_r <= 32'h00000000;
        rsel_r <= 4'h0;
        ccr_r <= 5'h00;
        err_r <= 1'b0;
        rd_r <= 32'h00000000;
        maddr_r <= 32'h00000000;
        mem_req_out <= 1'b0;
        mem_we_out <= 1'b0;
        mem_size_out <= 2'h0;
        mem_addr_out <= 32'h00000000;
        mem_wdata_out <= 32'h00000000;
        for (k = 0; k < 16; k = k + 1)
            rf_r[k] <= 32'h00000000;
    end else if (clk_en_in) begin
        if (wr_ok) begin
            case (paddr_in)
                `OFS_CMD: begin
                    cmd_r <= wd_in;
                    phase_r <= 4'h0;
                    if (!cmd_bad)
                        state_r <= S_RUN;
                end
                `OFS_SRCA: srca_r <= wd_in;
                `OFS_DSTA: dsta_r <= wd_in;
                `OFS_DISP: disp_r <= wd_in;
                `OFS_STAT: ccr_r <= wd_in[4:0];
                `OFS_RSEL: rsel_r <= wd_in[3:0];
                `OFS_RDAT: rf_r[rsel_r] <= wd_in;
                default: ;
            endcase
            if (paddr_in == `OFS_STAT && wd_in[`STAT_ERR])
                err_r <= 1'b0;
            if (paddr_in == `OFS_CMD && cmd_bad)
                err_r <= 1'b1;
        end
        case (state_r)
            S_IDLE: ;
            S_MEM: begin
                if (mem_ack_in) begin
                    mem_req_out <= 1'b0;
                    rd_r <= mem_rdata_in;
                    phase_r <= phase_r + 4'h1;
                    state_r <= S_RUN;
                end
            end
            S_RUN: begin
                case (op)
                    `OP_MOVE, `OP_ADDR_MOVE: begin
                        if (phase_r == 4'h0) begin
                            if (smem) begin
                                mem_req_out <= 1'b1;
                                mem_we_out <= 1'b0;
                                mem_size_out <= sz;
                                mem_addr_out <= srca_r;
                                state_r <= S_MEM;
                            end else begin
                                rd_r <= rf_r[rx];
                                phase_r <= 4'h1;
                            end
                        end else if (phase_r == 4'h1 && op == `OP_ADDR_MOVE) begin
                            rf_r[ay] <= ld_val;
                            state_r <= S_IDLE;
                        end else if (phase_r == 4'h1) begin
                            ccr_r[3:0] <= {msb(mv_val, sz), mv_val == 0, 2'b00};
                            if (dmem) begin
                                mem_req_out <= 1'b1;
                                mem_we_out <= 1'b1;
                                mem_size_out <= sz;
                                mem_addr_out <= dsta_r;
                                mem_wdata_out <= mv_val;
                                state_r <= S_MEM;
                            end else begin
                                rf_r[ry] <= merge(rf_r[ry], rd_r, sz);
                                state_r <= S_IDLE;
                            end
                        end else begin
                            state_r <= S_IDLE;
                        end
                    end
                    `OP_SWAP: begin
                        rf_r[rx] <= rf_r[ry];
                        rf_r[ry] <= rf_r[rx];
                        state_r <= S_IDLE;
                    end
                    `OP_EA_LOAD: begin
                        rf_r[ay] <= eaddr;
                        state_r <= S_IDLE;
                    end
                    `OP_LINK, `OP_EA_PUSH: begin
                        if (phase_r == 4'h0) begin
                            rd_r <= (op == `OP_EA_PUSH) ? eaddr : rf_r[ay];
                            rf_r[`STACK_IDX] <= stk_top - `STACK_STEP;
                            phase_r <= 4'h1;
                        end else if (phase_r == 4'h1) begin
                            mem_req_out <= 1'b1;
                            mem_we_out <= 1'b1;
                            mem_size_out <= `SZ_LONG;
                            mem_addr_out <= stk_top;
                            mem_wdata_out <= rd_r;
                            state_r <= S_MEM;
                        end else begin
                            if (op == `OP_LINK) begin
                                rf_r[ay] <= stk_top;
                                rf_r[`STACK_IDX] <= stk_top + disp_r;
                            end
                            state_r <= S_IDLE;
                        end
                    end
                    `OP_UNLINK: begin
                        if (phase_r == 4'h0) begin
                            rf_r[`STACK_IDX] <= rf_r[ay];
                            phase_r <= 4'h1;
                        end else if (phase_r == 4'h1) begin
                            mem_req_out <= 1'b1;
                            mem_we_out <= 1'b0;
                            mem_size_out <= `SZ_LONG;
                            mem_addr_out <= stk_top;
                            state_r <= S_MEM;
                        end else begin
                            rf_r[ay] <= rd_r;
                            rf_r[`STACK_IDX] <= stk_top + `STACK_STEP;
                            state_r <= S_IDLE;
                        end
                    end
                    `OP_MULTI: begin
                        if (phase_r == 4'h0) begin
                            idx_r <= 4'h0;
                            maddr_r <= dir ? srca_r : dsta_r;
                            phase_r <= 4'h1;
                        end else if (phase_r == 4'h1) begin
                            if (disp_r[idx_r]) begin
                                mem_req_out <= 1'b1;
                                mem_we_out <= ~dir;
                                mem_size_out <= sz;
                                mem_addr_out <= maddr_r;
                                mem_wdata_out <= rf_r[idx_r] & szmask(sz);
                                state_r <= S_MEM;
                            end else if (idx_r == 4'hF) begin
                                state_r <= S_IDLE;
                            end else begin
                                idx_r <= idx_r + 4'h1;
                            end
                        end else begin
                            if (dir)
                                rf_r[idx_r] <= ld_val;
                            maddr_r <= maddr_r + ((sz == `SZ_WORD) ?
                                32'h00000002 : 32'h00000004);
                            phase_r <= 4'h1;
                            if (idx_r == 4'hF)
                                state_r <= S_IDLE;
                            else
                                idx_r <= idx_r + 4'h1;
                        end
                    end
                    `OP_PBYTE: begin
                        if (phase_r == 4'h0) begin
                            idx_r <= 4'h0;
                            maddr_r <= rf_r[ay] + disp_r;
                            phase_r <= 4'h1;
                        end else if (phase_r == 4'h1) begin
                            mem_req_out <= 1'b1;
                            mem_we_out <= ~dir;
                            mem_size_out <= `SZ_BYTE;
                            mem_addr_out <= maddr_r;
                            mem_wdata_out <= (rf_r[dx] & pb_lane) >> pb_sh;
                            state_r <= S_MEM;
                        end else begin
                            if (dir)
                                rf_r[dx] <= (rf_r[dx] & ~pb_lane) |
                                    ({24'h000000, rd_r[7:0]} << pb_sh);
                            maddr_r <= maddr_r + `PBYTE_STEP;
                            phase_r <= 4'h1;
                            if (idx_r[2:0] == pb_last)
                                state_r <= S_IDLE;
                            else
                                idx_r <= idx_r + 4'h1;
                        end
                    end
                    `OP_QUICK: begin
                        rf_r[dy] <= quick;
                        ccr_r[3:0] <= {quick[31], quick == 0, 2'b00};
                        state_r <= S_IDLE;
                    end
                    `OP_ROT_RIGHT: begin
                        rf_r[dy] <= merge(rf_r[dy], rot, sz);
                        ccr_r[3:0] <= {msb(rot, sz), (rot & szmask(sz)) == 0,
                            1'b0, (disp_r[5:0] != 6'h00) & msb(rot, sz)};
                        state_r <= S_IDLE;
                    end
                    default: state_r <= S_IDLE;
                endcase
            end
            default: state_r <= S_IDLE;
        endcase
    end
end
endmodule
`default_nettype wire

/* File: test/data_move_rotate_flags_checker.sv */
// Port checker for the data move and rotate datapath
`default_nettype none
module data_move_rotate_flags_checker (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic clk_en_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic mem_req_out,
    input wire logic mem_we_out,
    input wire logic [1:0] mem_size_out,
    input wire logic [31:0] mem_addr_out,
    input wire logic [31:0] mem_wdata_out,
    input wire logic [31:0] mem_rdata_in,
    input wire logic mem_ack_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic acc;
    assign acc = psel_in && penable_in;
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rstn_in);
    ready_follows_en_a: assert property (pready_out == clk_en_in)
        else $error("pready differs from clock enable");
    err_in_access_a: assert property (pslverr_out |-> acc)
        else $error("error outside an access phase");
    bad_addr_err_a: assert property (acc && (paddr_in > 8'h18
        || paddr_in[1:0] != 2'h0) |-> pslverr_out)
        else $error("unmapped address not refused");
    err_read_zero_a: assert property (acc && !pwrite_in && pslverr_out
        |-> prdata_out == 32'h0)
        else $error("refused read returns data");
    req_hold_a: assert property (mem_req_out && !mem_ack_in |=> mem_req_out
        && $stable(mem_addr_out) && $stable(mem_wdata_out)
        && $stable(mem_we_out) && $stable(mem_size_out))
        else $error("memory request changed before acknowledge");
    req_release_a: assert property (mem_req_out && mem_ack_in |=> !mem_req_out)
        else $error("memory request held after acknowledge");
    legal_size_a: assert property (mem_req_out |-> mem_size_out != 2'h3)
        else $error("memory request with illegal size");
    reset_quiet_a: assert property ($rose(rstn_in) |-> !mem_req_out
        && !pslverr_out && prdata_out == 32'h0)
        else $error("outputs active after reset");
    cover property (mem_req_out && mem_ack_in && mem_we_out);
    cover property (mem_req_out && !mem_ack_in [*3]);
    cover property (acc && pslverr_out);
endmodule
bind data_move_rotate_flags data_move_rotate_flags_checker u_chk (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .clk_en_in(clk_en_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .mem_req_out(mem_req_out), .mem_we_out(mem_we_out),
    .mem_size_out(mem_size_out), .mem_addr_out(mem_addr_out),
    .mem_wdata_out(mem_wdata_out), .mem_rdata_in(mem_rdata_in),
    .mem_ack_in(mem_ack_in));
`default_nettype wire

/* File: test/operand_mem.sv */
// Operand memory model answering the datapath's memory requests
`default_nettype none
module operand_mem (
    input wire logic clk_sys_in,
    input wire logic [3:0] wait_in,
    input wire logic mem_req_in,
    input wire logic mem_we_in,
    input wire logic [1:0] mem_size_in,
    input wire logic [31:0] mem_addr_in,
    input wire logic [31:0] mem_wdata_in,
    output var logic [31:0] mem_rdata_out,
    output var logic mem_ack_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:255];
    logic [3:0] cnt_r;
    logic [31:0] v;
    int n, acks;
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 8'h00;
        cnt_r = 4'h0;
        acks = 0;
        mem_ack_out = 1'b0;
        mem_rdata_out = 32'h0;
    end
    // Big-endian bytes; answers after wait_in cycles, then data is inverted
    always @(posedge clk_sys_in) begin
        mem_ack_out <= 1'b0;
        n = (mem_size_in == 2'h0) ? 1 : (mem_size_in == 2'h1) ? 2 : 4;
        if (mem_ack_out) begin
            cnt_r <= 4'h0;
            mem_rdata_out <= ~mem_rdata_out;
        end else if (mem_req_in && cnt_r < wait_in) begin
            cnt_r <= cnt_r + 4'h1;
        end else if (mem_req_in) begin
            mem_ack_out <= 1'b1;
            acks <= acks + 1;
            v = 32'h0;
            for (int i = 0; i < n; i++) begin
                if (mem_we_in)
                    mem[mem_addr_in[7:0] + 8'(i)] <= mem_wdata_in[8*(n-1-i) +: 8];
                v = {v[23:0], mem[mem_addr_in[7:0] + 8'(i)]};
            end
            mem_rdata_out <= v;
        end
    end
endmodule
`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench for the data move and rotate datapath
`include "data_move_rotate_flags_consts.vh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_in = 1'b0, rstn_in = 1'b0, psel_in = 1'b0;
    logic penable_in = 1'b0, pwrite_in = 1'b0, er;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
    logic [31:0] mem_addr_out, mem_wdata_out, mem_rdata_in;
    logic pready_out, pslverr_out, mem_req_out, mem_we_out, mem_ack_in;
    logic [1:0] mem_size_out;
    logic [3:0] mwait = 4'h0;
    int mismatches = 0, compares = 0, na;
    logic [3:0] t_op [0:6] = '{`OP_QUICK, `OP_QUICK, `OP_QUICK,
        `OP_ROT_RIGHT, `OP_ROT_RIGHT, `OP_ROT_RIGHT, `OP_ROT_RIGHT};
    logic [31:0] t_d [0:6] = '{32'h80, 32'h0, 32'h7F, 32'h1, 32'h0, 32'h4,
        32'h3};
    logic [31:0] t_in [0:6] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF,
        32'h1, 32'h80000000, 32'h80000000, 32'h0};
    logic [31:0] t_out [0:6] = '{32'hFFFFFF80, 32'h0, 32'h7F, 32'h80000000,
        32'h80000000, 32'h08000000, 32'h0};
    logic [31:0] t_cc [0:6] = '{32'h18, 32'h14, 32'h10, 32'h19, 32'h18,
        32'h10, 32'h14};
    always #25 clk_sys_in = ~clk_sys_in;
    data_move_rotate_flags u_dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
        .clk_en_in(1'b1), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
        .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .mem_req_out(mem_req_out),
        .mem_we_out(mem_we_out), .mem_size_out(mem_size_out),
        .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
        .mem_rdata_in(mem_rdata_in), .mem_ack_in(mem_ack_in));
    operand_mem u_mem (.clk_sys_in(clk_sys_in), .wait_in(mwait),
        .mem_req_in(mem_req_out), .mem_we_in(mem_we_out),
        .mem_size_in(mem_size_out), .mem_addr_in(mem_addr_out),
        .mem_wdata_in(mem_wdata_out), .mem_rdata_out(mem_rdata_in),
        .mem_ack_out(mem_ack_in));
    // ----------------------------------------
    // Bus tasks and checks
    // ----------------------------------------
    task end_sim;
        if (mismatches == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_sys_in);
        penable_in <= 1'b1;
        @(posedge clk_sys_in);
        while (pready_out !== 1'b1) @(posedge clk_sys_in);
        rd = prdata_out;
        er = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task poll;
        rd = 32'h100;
        while (rd[`STAT_BUSY] !== 1'b0) apb(1'b0, `OFS_STAT, 32'h0);
    endtask
    task go(input logic [31:0] c, input logic [31:0] d);
        apb(1'b1, `OFS_DISP, d);
        apb(1'b1, `OFS_CMD, c);
        poll;
    endtask
    task setr(input logic [3:0] i, input logic [31:0] v);
        apb(1'b1, `OFS_RSEL, {28'h0, i});
        apb(1'b1, `OFS_RDAT, v);
    endtask
    task creg(input logic [3:0] i, input logic [31:0] e);
        apb(1'b1, `OFS_RSEL, {28'h0, i});
        apb(1'b0, `OFS_RDAT, 32'h0);
        chk($sformatf("reg%0d", i), rd, e);
    endtask
    function logic [31:0] cmd(input logic [3:0] op, input logic [1:0] sz,
        input logic [3:0] rx, input logic [3:0] ry, input logic [2:0] f);
        return {13'h0, f, ry, rx, 2'h0, sz, op};
    endfunction
    function logic [31:0] ml(input logic [7:0] a);
        return {u_mem.mem[a], u_mem.mem[a + 8'h1], u_mem.mem[a + 8'h2],
            u_mem.mem[a + 8'h3]};
    endfunction
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (30000) @(posedge clk_sys_in);
        mismatches++;
        end_sim;
    end
    initial begin
        repeat (4) @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        apb(1'b0, `OFS_STAT, 32'h0);
        chk("stat", rd, 32'h0);
        for (int k = 0; k < 7; k++) begin
            setr(4'h2, t_in[k]);
            apb(1'b1, `OFS_STAT, 32'h13);
            go(cmd(t_op[k], `SZ_LONG, 4'h0, 4'h2, 3'h0), t_d[k]);
            chk("ccr", {27'h0, rd[4:0]}, t_cc[k]);
            creg(4'h2, t_out[k]);
        end
        setr(4'h1, 32'h00008001);
        apb(1'b1, `OFS_STAT, 32'h0A);
        go(cmd(`OP_ADDR_MOVE, `SZ_WORD, 4'h1, 4'h2, 3'h0), 32'h0);
        chk("ccr", rd, 32'h0A);
        creg(4'hA, 32'hFFFF8001);
        go(cmd(`OP_ADDR_MOVE, `SZ_BYTE, 4'h1, 4'h3, 3'h0), 32'h0);
        chk("err", {31'h0, rd[`STAT_ERR]}, 32'h1);
        creg(4'hB, 32'h0);
        apb(1'b1, `OFS_STAT, 32'h200);
        setr(4'h3, 32'hAAAA5555);
        setr(4'hC, 32'h0F0F1234);
        go(cmd(`OP_SWAP, `SZ_LONG, 4'h3, 4'hC, 3'h0), 32'h0);
        creg(4'h3, 32'h0F0F1234);
        creg(4'hC, 32'hAAAA5555);
        setr(4'h5, 32'h40);
        na = u_mem.acks;
        go(cmd(`OP_EA_LOAD, `SZ_LONG, 4'h5, 4'h1, 3'h0), 32'h10);
        creg(4'h9, 32'h50);
        chk("acks", u_mem.acks, na);
        setr(4'hF, 32'h80);
        mwait <= 4'h6;
        apb(1'b1, `OFS_DISP, 32'h10);
        apb(1'b1, `OFS_CMD, cmd(`OP_EA_PUSH, `SZ_LONG, 4'h5, 4'h0, 3'h0));
        apb(1'b1, `OFS_RSEL, 32'h1);
        chk("busy_err", {31'h0, er}, 32'h1);
        poll;
        creg(4'hF, 32'h7C);
        chk("push", ml(8'h7C), 32'h50);
        setr(4'hB, 32'h12345678);
        go(cmd(`OP_LINK, `SZ_LONG, 4'h0, 4'h3, 3'h0), 32'hFFFFFFF8);
        creg(4'hF, 32'h70);
        creg(4'hB, 32'h78);
        chk("link", ml(8'h78), 32'h12345678);
        go(cmd(`OP_UNLINK, `SZ_LONG, 4'h0, 4'h3, 3'h0), 32'h0);
        creg(4'hB, 32'h12345678);
        creg(4'hF, 32'h7C);
        mwait <= 4'h0;
        setr(4'h2, 32'hA1B2C3D4);
        setr(4'hE, 32'h20);
        go(cmd(`OP_PBYTE, `SZ_LONG, 4'h2, 4'h6, 3'h0), 32'h1);
        chk("pb_lo", ml(8'h20), 32'h00A100B2);
        chk("pb_hi", ml(8'h24), 32'h00C300D4);
        go(cmd(`OP_PBYTE, `SZ_WORD, 4'h7, 4'h6, 3'h1), 32'h1);
        creg(4'h7, 32'h0000A1B2);
        go(cmd(`OP_PBYTE, `SZ_LONG, 4'h0, 4'h6, 3'h1), 32'h1);
        creg(4'h0, 32'hA1B2C3D4);
        setr(4'h4, 32'hFFFFFFFF);
        go(cmd(`OP_MOVE, `SZ_BYTE, 4'h0, 4'h4, 3'h0), 32'h0);
        creg(4'h4, 32'hFFFFFFD4);
        apb(1'b1, `OFS_SRCA, 32'h78);
        apb(1'b1, `OFS_DSTA, 32'h40);
        go(cmd(`OP_MOVE, `SZ_LONG, 4'h0, 4'h0, 3'h6), 32'h0);
        chk("mv_mm", ml(8'h40), 32'h12345678);
        go(cmd(`OP_MULTI, `SZ_LONG, 4'h0, 4'h0, 3'h0), 32'h1);
        chk("multi", ml(8'h40), 32'hA1B2C3D4);
        apb(1'b1, `OFS_SRCA, 32'h40);
        go(cmd(`OP_MULTI, `SZ_WORD, 4'h0, 4'h0, 3'h1), 32'h6);
        creg(4'h1, 32'hFFFFA1B2);
        creg(4'h2, 32'hFFFFC3D4);
        go(cmd(`OP_MULTI, `SZ_BYTE, 4'h0, 4'h0, 3'h1), 32'h1);
        chk("multi_err", {31'h0, rd[`STAT_ERR]}, 32'h1);
        apb(1'b0, 8'h1C, 32'h0);
        chk("unmapped", {31'h0, er}, 32'h1);
        chk("unmapped_data", rd, 32'h0);
        end_sim;
    end
endmodule
`default_nettype wire
